// file: hps_pkg.sv
/*
 * Shared constants and types for the host port: strap codes, device register
 * map, controller register map, timing counts and state types.
 * Assumes both ends and the carrier interface import it.
 */
package hps_pkg;
	// ************************************************************
	// Widths
	// ************************************************************
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int SEL_W  = 3;
	localparam int AXI_AW = 4;
	localparam int AXI_DW = 32;

	// ************************************************************
	// Interface select strap codes
	// ************************************************************
	localparam logic [2:0] SEL_SEP_MUX = 3'h2;
	localparam logic [2:0] SEL_SEP_DIR = 3'h3;
	localparam logic [2:0] SEL_DS_DIR  = 3'h4;
	localparam logic [2:0] SEL_SPI_LSB = 3'h5;
	localparam logic [2:0] SEL_DS_MUX  = 3'h6;
	localparam logic [2:0] SEL_SPI_MSB = 3'h7;

	// ************************************************************
	// Device register map
	// ************************************************************
	localparam int         SCRATCH_N_DEF = 8;
	localparam logic [8:0] ADDR_MASTER_CONFIG_REG3     = 9'h010;
	localparam logic [8:0] ADDR_OC4      = 9'h011;
	localparam logic [8:0] ADDR_HPCR     = 9'h012;
	localparam int         RATE_BIT      = 0;
	localparam logic [7:0] REG_RST       = 8'h00;
	localparam logic [7:0] BUS_IDLE      = 8'hFF;

	// ************************************************************
	// Controller register map
	// ************************************************************
	localparam logic [3:0] OFF_CMD        = 4'h0;
	localparam logic [3:0] OFF_STAT       = 4'h4;
	localparam logic [3:0] OFF_MODE       = 4'h8;
	localparam int         CMD_ADDR_LSB   = 8;
	localparam int         CMD_READ_BIT   = 24;
	localparam int         MODE_RESET_BIT = 7;
	localparam logic [5:0] MODE_RST       = 6'h33;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int RST_MIN_REF_CYC = 2;
	localparam int RST_HOLD_CYC    = RST_MIN_REF_CYC + 2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {M_SEP_MUX, M_SEP_DIR, M_DS_DIR, M_DS_MUX, M_SPI_LSB, M_SPI_MSB, M_UNDEF} hps_mode_t;
	typedef enum logic [1:0] {D_IDLE, D_READ, D_WRITE, D_HOLD} hps_dev_st_t;
	typedef enum logic [2:0] {B_IDLE, B_ADDR, B_LATCH, B_STROBE, B_WAIT, B_RELEASE} hps_bus_st_t;
endpackage

// file: hps_port_if.sv
/*
 * Pin-level carrier between the host controller and the device port.
 * Assumes the testbench ties it to both ends; shared pins resolve here.
 */
`timescale 1ns/1ps
interface hps_port_if;
	import hps_pkg::*;
	logic              reset_n_pin;
	logic              output_float_n;
	logic              test_port_reset_n;
	logic [SEL_W-1:0]  host_port_select;
	logic              rate_family_select;
	logic              addr_latch_strobe;
	logic              chip_select_n;
	logic              store_dir_pin;
	logic              read_data_strobe_n;
	logic [ADDR_W-1:0] upper_addr_pins;
	logic [DATA_W-1:0] host_ad_out;
	logic              host_ad_oe;
	logic [DATA_W-1:0] dev_ad_out;
	logic              dev_ad_oe;
	logic              done_ack_n_out;
	logic              done_ack_oe;
	logic [DATA_W-1:0] muxed_bus_pins;
	logic              done_ack_n;

	// Undriven lines settle high, like a pull-up
	assign muxed_bus_pins = host_ad_oe ? host_ad_out : (dev_ad_oe ? dev_ad_out : BUS_IDLE);
	assign done_ack_n     = done_ack_oe ? done_ack_n_out : 1'b1;

	modport device (
		input  reset_n_pin, output_float_n, test_port_reset_n, host_port_select, rate_family_select,
		input  addr_latch_strobe, chip_select_n, store_dir_pin, read_data_strobe_n, upper_addr_pins,
		input  muxed_bus_pins,
		output dev_ad_out, dev_ad_oe, done_ack_n_out, done_ack_oe
	);
	modport host (
		output reset_n_pin, output_float_n, test_port_reset_n, host_port_select, rate_family_select,
		output addr_latch_strobe, chip_select_n, store_dir_pin, read_data_strobe_n, upper_addr_pins,
		output host_ad_out, host_ad_oe,
		input  muxed_bus_pins, done_ack_n
	);
endinterface

// file: hps_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes the bits are independent levels or are held stable as a group.
 */
`timescale 1ns/1ps
module hps_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk, // clock
	input  wire logic [W-1:0] d,    // asynchronous levels
	output logic      [W-1:0] q     // synchronised levels
);
	logic [W-1:0] meta_q;

	// No reset: straps must pass through while the device is in reset
	always_ff @(posedge aclk) begin
		meta_q <= d;
		q      <= meta_q;
	end
endmodule

// file: hps_device_end.sv
/*
 * Device end of the parallel host port: reset handling, strap capture,
 * bus style decode, address latch, strobe decode, small register file,
 * output float and done acknowledge.
 * Assumes pins arrive asynchronously and that the host keeps its own rules.
 */
`timescale 1ns/1ps

// Overview of operation
// R1 - Reset pin low clears all internal state
// R2 - Host holds reset low two clocks minimum
// R3 - Float and test reset low tristate outputs
// R4 - Straps captured into config register during reset
// R5 - Decode four parallel bus styles from code
// R6 - Codes 101, 111 choose serial, LSB/MSB first
// R7 - Host never straps codes 000 or 001
// R8 - Rate strap sets rate bits reset default
// R9 - Address latched by strobe, muxed or separate
// R10 - Non-muxed modes: host holds latch strobe high
// R11 - Chip select low required; else bus ignored
// R12 - Separate strobes: store strobe low writes
// R13 - Separate strobes: read strobe low reads
// R14 - Data strobe modes: direction high reads
// R15 - Read drives on strobe fall, write on rise; code writes on store strobe fall in separate-strobe modes
// R16 - Muxed modes ignore low upper address pins
// R17 - Muxed pins are data bus, also address
// R18 - Done acknowledge low when access finished
// R19 - Captured select holds until next reset
module hps_device_end
	import hps_pkg::*;
#(
	parameter int SCRATCH_N = SCRATCH_N_DEF
) (
	input  wire logic             aclk,          // clock
	input  wire logic             aresetn,       // local reset, active low
	hps_port_if.device            port,          // pins
	output logic      [SEL_W-1:0] active_select, // captured interface select
	output logic                  master_config_reg3_rate_q,   // rate bit, master config 3
	output logic                  oc4_rate_q     // output_rate_family_bit
);
	localparam int SYNC_W = 10 + ADDR_W + DATA_W;
	localparam int IDX_W  = $clog2(SCRATCH_N);

	// ************************************************************
	// Reset
	// ************************************************************
	logic [1:0] rst_q;
	logic       rst_n;

	// Assert at once, release after two clean edges
	always_ff @(posedge aclk or negedge port.reset_n_pin) begin
		if (!port.reset_n_pin) begin
			rst_q <= 2'h0; // R1
		end else begin
			rst_q <= {rst_q[0], aresetn};
		end
	end
	assign rst_n = rst_q[1];

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [SYNC_W-1:0] pins_s;
	logic              float_n_s;
	logic              trst_n_s;
	logic [SEL_W-1:0]  sel_s;
	logic              rate_s;
	logic              ale_s;
	logic              cs_n_s;
	logic              sdir_s;
	logic              rds_n_s;
	logic [ADDR_W-1:0] upper_s;
	logic [DATA_W-1:0] ad_s;

	hps_sync #(.W(SYNC_W)) u_sync (
		.aclk (aclk),
		.d    ({port.output_float_n, port.test_port_reset_n, port.host_port_select,
		        port.rate_family_select, port.addr_latch_strobe, port.chip_select_n,
		        port.store_dir_pin, port.read_data_strobe_n, port.upper_addr_pins,
		        port.muxed_bus_pins}),
		.q    (pins_s)
	);
	assign {float_n_s, trst_n_s, sel_s, rate_s, ale_s, cs_n_s, sdir_s, rds_n_s, upper_s, ad_s} = pins_s;

	// ************************************************************
	// Strap capture
	// ************************************************************
	logic [SEL_W-1:0] sel_q;

	// Loads only while reset is held, so later strap changes are ignored
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			sel_q <= sel_s; // R4 R19
		end
	end
	assign active_select = sel_q;

	// ************************************************************
	// Bus style decode
	// ************************************************************
	hps_mode_t mode;
	logic      is_par;
	logic      is_mux;
	logic      is_ds;

	always_comb begin
		case (sel_q)
			SEL_SEP_MUX: mode = M_SEP_MUX; // R5
			SEL_SEP_DIR: mode = M_SEP_DIR; // R5
			SEL_DS_DIR:  mode = M_DS_DIR;  // R5
			SEL_DS_MUX:  mode = M_DS_MUX;  // R5
			SEL_SPI_LSB: mode = M_SPI_LSB; // R6
			SEL_SPI_MSB: mode = M_SPI_MSB; // R6
			default:     mode = M_UNDEF;
		endcase
	end
	// Serial modes leave the parallel port idle; framing lives elsewhere
	assign is_par = (mode == M_SEP_MUX) || (mode == M_SEP_DIR) || (mode == M_DS_DIR) || (mode == M_DS_MUX);
	assign is_mux = (mode == M_SEP_MUX) || (mode == M_DS_MUX);
	assign is_ds  = (mode == M_DS_DIR) || (mode == M_DS_MUX);

	// ************************************************************
	// Address latch
	// ************************************************************
	logic [ADDR_W-1:0] addr_q;

	always_ff @(posedge aclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= '0;
		end else if (is_par && ale_s) begin
			addr_q <= is_mux ? {upper_s[ADDR_W-1], ad_s} : upper_s; // R9 R16 R17
		end
	end

	// ************************************************************
	// Strobe decode and access sequencer
	// ************************************************************
	logic        strobe_act;
	logic        is_rd;
	logic        sel_ok;
	logic        wr_en;
	hps_dev_st_t st_q;
	hps_dev_st_t st_d;

	assign strobe_act = is_ds ? !rds_n_s : (!rds_n_s || !sdir_s); // R12 R13
	assign is_rd      = is_ds ? sdir_s : !rds_n_s;                // R13 R14
	assign sel_ok     = is_par && !cs_n_s;                        // R11

	always_comb begin
		st_d  = st_q;
		wr_en = 1'b0;
		case (st_q)
			D_IDLE: begin
				if (sel_ok && strobe_act) begin
					if (is_rd) begin
						st_d = D_READ;
					end else if (is_ds) begin
						st_d = D_WRITE;
					end else begin
						wr_en = 1'b1; // R12
						st_d  = D_HOLD;
					end
				end
			end
			D_READ: begin
				if (!strobe_act || cs_n_s) begin
					st_d = D_IDLE;
				end
			end
			D_WRITE: begin
				if (!strobe_act) begin
					wr_en = 1'b1; // R15
					st_d  = D_IDLE;
				end else if (cs_n_s) begin
					st_d = D_IDLE;
				end
			end
			D_HOLD: begin
				if (!strobe_act || cs_n_s) begin
					st_d = D_IDLE;
				end
			end
			default: st_d = D_IDLE;
		endcase
	end

	always_ff @(posedge aclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= D_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************
	logic [DATA_W-1:0] scratch_q [SCRATCH_N];
	logic              scr_hit;
	logic [IDX_W-1:0]  scr_idx;
	logic [DATA_W-1:0] rd_data;

	assign scr_hit = addr_q < ADDR_W'(SCRATCH_N);
	assign scr_idx = addr_q[IDX_W-1:0];

	for (genvar g = 0; g < SCRATCH_N; g++) begin : g_scratch
		always_ff @(posedge aclk or negedge rst_n) begin
			if (!rst_n) begin
				scratch_q[g] <= REG_RST;
			end else if (wr_en && scr_hit && (scr_idx == IDX_W'(g))) begin
				scratch_q[g] <= ad_s;
			end
		end
	end

	// Strap-loaded defaults cannot sit behind a constant-only async reset
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			master_config_reg3_rate_q <= rate_s; // R8
			oc4_rate_q  <= rate_s; // R8
		end else if (wr_en && (addr_q == ADDR_MASTER_CONFIG_REG3)) begin
			master_config_reg3_rate_q <= ad_s[RATE_BIT];
		end else if (wr_en && (addr_q == ADDR_OC4)) begin
			oc4_rate_q <= ad_s[RATE_BIT];
		end
	end

	always_comb begin
		case (addr_q)
			ADDR_MASTER_CONFIG_REG3: rd_data = DATA_W'(master_config_reg3_rate_q);
			ADDR_OC4:  rd_data = DATA_W'(oc4_rate_q);
			ADDR_HPCR: rd_data = DATA_W'(sel_q);
			default:   rd_data = scr_hit ? scratch_q[scr_idx] : REG_RST;
		endcase
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************
	logic float_now;

	assign float_now = !float_n_s && !trst_n_s; // R3

	always_ff @(posedge aclk or negedge rst_n) begin
		if (!rst_n) begin
			port.dev_ad_out     <= REG_RST;
			port.dev_ad_oe      <= 1'b0;
			port.done_ack_n_out <= 1'b1;
			port.done_ack_oe    <= 1'b1;
		end else begin
			port.dev_ad_out     <= rd_data;
			port.dev_ad_oe      <= !float_now && (st_d == D_READ); // R15 R17 R3
			port.done_ack_n_out <= (st_d == D_IDLE);               // R18
			port.done_ack_oe    <= !float_now;                     // R3
		end
	end
endmodule

// file: hps_host_end.sv
/*
 * Host controller for the parallel port: AXI4-Lite register slave, reset
 * pulse and strap driver, and the bus cycle sequencer for all four styles.
 * Assumes aclk is also the device reference clock.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module hps_host_end
	import hps_pkg::*;
#(
	parameter int RST_HOLD = RST_HOLD_CYC
) (
	input  wire logic              aclk,    // clock
	input  wire logic              aresetn, // reset, active low
	input  wire logic              awvalid, // write address valid
	output logic                   awready, // write address ready
	input  wire logic [AXI_AW-1:0] awaddr,  // write address
	input  wire logic              wvalid,  // write data valid
	output logic                   wready,  // write data ready
	input  wire logic [AXI_DW-1:0] wdata,   // write data
	input  wire logic [3:0]        wstrb,   // byte enables
	output logic                   bvalid,  // write response valid
	input  wire logic              bready,  // write response ready
	output logic      [1:0]        bresp,   // write response
	input  wire logic              arvalid, // read address valid
	output logic                   arready, // read address ready
	input  wire logic [AXI_AW-1:0] araddr,  // read address
	output logic                   rvalid,  // read data valid
	input  wire logic              rready,  // read data ready
	output logic      [AXI_DW-1:0] rdata,   // read data
	output logic      [1:0]        rresp,   // read response
	hps_port_if.host               port     // pins
);
	// ************************************************************
	// AXI write channel
	// ************************************************************
	logic [AXI_AW-1:0] awa_q;
	logic [AXI_DW-1:0] wd_q;
	logic [3:0]        ws_q;
	logic              wr_fire;
	logic              busy_q;

	assign wr_fire = !awready && !wready && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awa_q   <= '0;
			wd_q    <= '0;
			ws_q    <= '0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awa_q   <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wd_q   <= wdata;
				ws_q   <= wstrb;
			end
			if (wr_fire) begin
				awready <= 1'b1;
				wready  <= 1'b1;
				bvalid  <= 1'b1;
				bresp   <= (awa_q == OFF_CMD || awa_q == OFF_STAT || awa_q == OFF_MODE) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	logic [5:0]        mode_q;
	logic [ADDR_W-1:0] c_addr_q;
	logic [DATA_W-1:0] c_wdata_q;
	logic              c_read_q;
	logic              start;
	logic              pulse_req;

	assign start     = wr_fire && (awa_q == OFF_CMD) && (ws_q == 4'hF) && !busy_q;
	assign pulse_req = wr_fire && (awa_q == OFF_MODE) && ws_q[0] && wd_q[MODE_RESET_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q    <= MODE_RST;
			c_addr_q  <= '0;
			c_wdata_q <= '0;
			c_read_q  <= 1'b0;
		end else begin
			if (wr_fire && (awa_q == OFF_MODE) && ws_q[0]) begin
				mode_q[5:3] <= wd_q[5:3];
				// Undefined select codes are refused, last code kept
				if (wd_q[2:1] != 2'h0) begin
					mode_q[2:0] <= wd_q[2:0]; // R7
				end
			end
			if (start) begin
				c_wdata_q <= wd_q[DATA_W-1:0];
				c_addr_q  <= wd_q[CMD_ADDR_LSB +: ADDR_W];
				c_read_q  <= wd_q[CMD_READ_BIT];
			end
		end
	end

	// ************************************************************
	// Device reset pulse and straps
	// ************************************************************
	logic [7:0]       rst_cnt_q;
	logic [SEL_W-1:0] bus_sel_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt_q        <= 8'(RST_HOLD);
			port.reset_n_pin <= 1'b0;
			bus_sel_q        <= MODE_RST[2:0];
		end else if (pulse_req) begin
			rst_cnt_q        <= 8'(RST_HOLD);
			port.reset_n_pin <= 1'b0;
		end else if (rst_cnt_q != 8'h00) begin
			rst_cnt_q        <= rst_cnt_q - 8'h01; // R2
			port.reset_n_pin <= 1'b0;
			bus_sel_q        <= mode_q[2:0];
		end else begin
			port.reset_n_pin <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.host_port_select   <= MODE_RST[2:0];
			port.rate_family_select <= MODE_RST[3];
			port.output_float_n     <= MODE_RST[4];
			port.test_port_reset_n  <= MODE_RST[5];
		end else begin
			port.host_port_select   <= mode_q[2:0];
			port.rate_family_select <= mode_q[3];
			port.output_float_n     <= mode_q[4];
			port.test_port_reset_n  <= mode_q[5];
		end
	end

	// ************************************************************
	// Bus cycle sequencer
	// ************************************************************
	logic [DATA_W:0]   back_s;
	logic              ack_n_s;
	logic [DATA_W-1:0] ad_s;
	logic              is_mux;
	logic              is_ds;
	hps_bus_st_t       st_q;
	logic              done_q;
	logic [DATA_W-1:0] rbyte_q;

	hps_sync #(.W(DATA_W + 1)) u_sync (
		.aclk (aclk),
		.d    ({port.done_ack_n, port.muxed_bus_pins}),
		.q    (back_s)
	);
	assign {ack_n_s, ad_s} = back_s;
	assign is_mux = (bus_sel_q == SEL_SEP_MUX) || (bus_sel_q == SEL_DS_MUX);
	assign is_ds  = (bus_sel_q == SEL_DS_DIR) || (bus_sel_q == SEL_DS_MUX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q                    <= B_IDLE;
			busy_q                  <= 1'b0;
			done_q                  <= 1'b0;
			rbyte_q                 <= REG_RST;
			port.addr_latch_strobe  <= 1'b1;
			port.chip_select_n      <= 1'b1;
			port.store_dir_pin      <= 1'b1;
			port.read_data_strobe_n <= 1'b1;
			port.upper_addr_pins    <= '0;
			port.host_ad_out        <= REG_RST;
			port.host_ad_oe         <= 1'b0;
		end else begin
			case (st_q)
				B_IDLE: begin
					port.addr_latch_strobe <= !is_mux; // R10
					if (start) begin
						busy_q <= 1'b1;
						done_q <= 1'b0;
						st_q   <= B_ADDR;
					end
				end
				B_ADDR: begin
					port.addr_latch_strobe <= 1'b1;
					port.store_dir_pin     <= is_ds ? c_read_q : 1'b1; // R14
					port.upper_addr_pins   <= is_mux ? {c_addr_q[ADDR_W-1], 8'h00} : c_addr_q; // R16
					port.host_ad_out       <= c_addr_q[DATA_W-1:0];
					port.host_ad_oe        <= is_mux;
					st_q                   <= B_LATCH;
				end
				B_LATCH: begin
					port.addr_latch_strobe <= !is_mux;
					st_q                   <= B_STROBE;
				end
				B_STROBE: begin
					port.chip_select_n      <= 1'b0; // R11
					port.read_data_strobe_n <= !(is_ds || c_read_q);
					port.store_dir_pin      <= is_ds ? c_read_q : c_read_q;
					port.host_ad_out        <= c_wdata_q;
					port.host_ad_oe         <= !c_read_q;
					st_q                    <= B_WAIT;
				end
				B_WAIT: begin
					// No timeout: a floated or absent device stalls here
					if (!ack_n_s) begin
						if (c_read_q) begin
							rbyte_q <= ad_s;
						end
						port.read_data_strobe_n <= 1'b1;
						port.store_dir_pin      <= 1'b1;
						port.chip_select_n      <= 1'b1;
						st_q                    <= B_RELEASE;
					end
				end
				B_RELEASE: begin
					// Write data held one cycle past the strobe edge
					port.host_ad_oe <= 1'b0;
					busy_q          <= 1'b0;
					done_q          <= 1'b1;
					st_q            <= B_IDLE;
				end
				default: st_q <= B_IDLE;
			endcase
		end
	end

	// ************************************************************
	// AXI read channel
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			case (araddr)
				OFF_CMD:  rdata <= AXI_DW'({c_read_q, 7'h00, c_addr_q, c_wdata_q});
				OFF_STAT: rdata <= AXI_DW'({rbyte_q, 6'h00, done_q, busy_q});
				OFF_MODE: rdata <= AXI_DW'({!port.reset_n_pin, 1'b0, mode_q});
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule

// file: hps_checker.sv
/* Pin checker for the host port carrier.
   Assumes it sits beside the carrier and that both ends run on aclk. */
`timescale 1ns/1ps
module hps_checker (
	input wire logic aclk,               // clock
	input wire logic aresetn,            // reset, active low
	input wire logic reset_n_pin,        // device reset pin
	input wire logic output_float_n,     // float request
	input wire logic test_port_reset_n,  // test port reset
	input wire logic chip_select_n,      // chip select
	input wire logic store_dir_pin,      // store strobe or direction
	input wire logic read_data_strobe_n, // read or data strobe
	input wire logic dev_ad_oe,          // device drives bus
	input wire logic done_ack_oe,        // device drives ack
	input wire logic done_ack_n          // resolved ack
);
	// ************************************************************
	// Pin properties
	// ************************************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst_quiet; !reset_n_pin |-> !dev_ad_oe && done_ack_n; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("device active in reset");
	property p_rst_len; $fell(reset_n_pin) |=> !reset_n_pin; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
	property p_float; (reset_n_pin && !output_float_n && !test_port_reset_n)[*4] |-> !dev_ad_oe && !done_ack_oe; endproperty
	a_float: assert property (p_float) else $error("outputs not floated");
	property p_cs_idle; chip_select_n[*5] |-> done_ack_n; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("ack without chip select");
	property p_ack; $fell(chip_select_n) && (output_float_n || test_port_reset_n) |-> ##[2:10] !done_ack_n; endproperty
	a_ack: assert property (p_ack) else $error("no ack after strobe");
	property p_ack_end; $rose(chip_select_n) |-> ##[1:6] done_ack_n; endproperty
	a_ack_end: assert property (p_ack_end) else $error("ack held after release");
	property p_rd_drive; !chip_select_n && store_dir_pin && !read_data_strobe_n && !done_ack_n |-> dev_ad_oe; endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
	property p_wr_quiet; (!chip_select_n && !store_dir_pin)[*4] |-> !dev_ad_oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("device drives in write");
	cover property ($rose(dev_ad_oe));
	cover property ($fell(store_dir_pin) && !chip_select_n);
	cover property (!output_float_n && !test_port_reset_n);
endmodule

// file: tb_host_port_select_and_strobe_bus.sv
/* Bench driving the host end over AXI4-Lite with the device end attached.
   Assumes both ends share aclk and a short device reset pulse. */
`timescale 1ns/1ps
module tb_host_port_select_and_strobe_bus import hps_pkg::*;;
	localparam logic [2:0] SELS [4] = '{SEL_SEP_MUX, SEL_SEP_DIR, SEL_DS_DIR, SEL_DS_MUX};
	logic             aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
	logic             awready, wready, bvalid, arready, rvalid, master_config_reg3_rate_q, oc4_rate_q;
	logic [3:0]       awaddr, araddr, wstrb;
	logic [31:0]      wdata, rdata, rd_q;
	logic [1:0]       bresp, rresp, rs_q;
	logic [SEL_W-1:0] active_select;
	int               errors = 0, checks = 0, cyc = 0;
	hps_port_if port();
	hps_device_end #(.SCRATCH_N(8)) i_hps_device_end (.*);
	hps_host_end #(.RST_HOLD(2)) i_hps_host_end (.*);
	hps_checker i_hps_checker (.aclk(aclk), .aresetn(aresetn), .reset_n_pin(port.reset_n_pin),
		.output_float_n(port.output_float_n), .test_port_reset_n(port.test_port_reset_n),
		.chip_select_n(port.chip_select_n), .store_dir_pin(port.store_dir_pin),
		.read_data_strobe_n(port.read_data_strobe_n), .dev_ad_oe(port.dev_ad_oe),
		.done_ack_oe(port.done_ack_oe), .done_ack_n(port.done_ack_n));
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end
	// Hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			end_sim;
		end
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task end_sim;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task axw(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!bvalid);
		rs_q = bresp;
	endtask
	task axr(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd_q = rdata;
		rs_q = rresp;
	endtask
	// One device access, polled until the done flag
	task acc(input logic [8:0] a, input logic [7:0] d, input logic rd);
		axw(OFF_CMD, {7'h00, rd, 7'h00, a, d});
		do axr(OFF_STAT); while (!rd_q[1]);
	endtask
	// Straps settle a few edges after the pulse ends
	task md(input logic [7:0] m);
		axw(OFF_MODE, {24'h000000, m});
		if (m[7]) do axr(OFF_MODE); while (rd_q[7]);
		repeat (6) @(posedge aclk);
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		aresetn = 1'h0;
		{awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		{bready, rready, wstrb} = 6'h3F;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			md({4'hB, i[0], SELS[i]});
			chk(active_select, SELS[i]);
			chk({master_config_reg3_rate_q, oc4_rate_q}, {2{i[0]}});
			acc(9'h000, {6'h28, i[1:0]}, 1'h0);
			acc(9'h100, 8'h33, 1'h0);
			acc(9'h007, 8'h5C, 1'h0);
			acc(9'h000, 8'h00, 1'h1);
			chk(rd_q[15:8], {6'h28, i[1:0]});
			acc(9'h007, 8'h00, 1'h1);
			chk(rd_q[15:8], 8'h5C);
			acc(9'h100, 8'h00, 1'h1);
			chk(rd_q[15:8], 8'h00);
			acc(ADDR_HPCR, 8'h00, 1'h1);
			chk(rd_q[15:8], {5'h00, SELS[i]});
		end
		acc(ADDR_MASTER_CONFIG_REG3, 8'h00, 1'h0);
		acc(ADDR_OC4, 8'h00, 1'h1);
		chk({rd_q[15:8], master_config_reg3_rate_q}, 9'h002);
		md(8'h34);
		chk(active_select, SEL_DS_MUX);
		md(8'h30);
		chk(port.host_port_select, 3'h4);
		md(8'h27);
		chk(port.done_ack_oe, 1'h1);
		md(8'h07);
		chk({port.done_ack_oe, port.dev_ad_oe}, 2'h0);
		md(8'hB5);
		chk(active_select, SEL_SPI_LSB);
		md(8'hB7);
		chk(active_select, SEL_SPI_MSB);
		md(8'hB2);
		acc(ADDR_HPCR, 8'h00, 1'h1);
		chk(rd_q[15:8], 8'h02);
		axr(4'hC);
		chk(rs_q, RESP_SLVERR);
		axw(4'hC, 32'h00000000);
		chk(rs_q, RESP_SLVERR);
		end_sim;
	end
endmodule
